// file: cpa_consts.vh
// register map and field constants for the clamp, power and level-control register group
// assumes an 8-bit subaddress register access from the serial control front end
`ifndef CPA_CONSTS_VH
`define CPA_CONSTS_VH

`define CPA_ADDR_FINE      8'h2a
`define CPA_ADDR_POWER     8'h2b
`define CPA_ADDR_CONV      8'h2c
`define CPA_ADDR_COARSE    8'h2d
`define CPA_ADDR_GSYNC     8'h2e
`define CPA_ADDR_RGBDROOP  8'h2f
`define CPA_ADDR_GSDROOP   8'h30
`define CPA_ADDR_LEVELPOS  8'h31
`define CPA_ADDR_CPTHR     8'h32
`define CPA_ADDR_SPTHR     8'h33

`define CPA_RST_FINE       8'h07
`define CPA_RST_POWER      8'h00
`define CPA_RST_CONV       8'h50
`define CPA_RST_COARSE     8'h00
`define CPA_RST_GSYNC      8'h80
`define CPA_RST_RGBDROOP   8'h8c
`define CPA_RST_GSDROOP    8'h04
`define CPA_RST_LEVELPOS   8'h5a
`define CPA_RST_CPTHR      8'h18
`define CPA_RST_SPTHR      8'h60

// writable bit masks; reserved bits hold their fixed values
`define CPA_WMASK_FINE     8'h9b
`define CPA_FIX_FINE       8'h04
`define CPA_WMASK_POWER    8'h7f
`define CPA_WMASK_COARSE   8'hc7
`define CPA_WMASK_GSYNC    8'he0
`define CPA_WMASK_DROOP    8'h3f
`define CPA_WMASK_FULL     8'hff

`define CPA_BIT_CMOFS      7
`define CPA_BIT_FINE_CLAMP_GREEN_BLUE_EN    1
`define CPA_BIT_FINE_R     0
`define CPA_BIT_GSYNC_EN   7

`define CPA_BIAS_BASE      6'h02
`define CPA_SP_CNT_W       8
`define CPA_CNT_ZERO       8'h00
`define CPA_CNT_ONE        8'h01

`endif

// file: cpa_level_window.v
// level-control window start: counts clock periods after the selected sync edge
// assumes hsync is already synchronous to clock
`timescale 1ns/1ns
`include "cpa_consts.vh"
module cpa_level_window (
  input  wire       clock,
  input  wire       rst_n,
  input  wire       hsync,
  input  wire       edgeLeading,
  input  wire [7:0] levelWindowOffset,
  output reg        windowStart
);
  reg       hsyncDly_ff;
  reg       busy_ff;
  reg [7:0] count_ff;
  wire      edgeSeen;

  assign edgeSeen = edgeLeading ? (hsync & ~hsyncDly_ff) : (~hsync & hsyncDly_ff);

  always @(posedge clock) begin
    if (!rst_n) begin
      hsyncDly_ff <= hsync; // track the input in reset so no false edge follows release
      busy_ff     <= 1'b0;
      count_ff    <= `CPA_CNT_ZERO;
      windowStart <= 1'b0;
    end else begin
      hsyncDly_ff <= hsync;
      windowStart <= 1'b0;
      if (edgeSeen) begin
        if (levelWindowOffset == `CPA_CNT_ZERO) begin
          windowStart <= 1'b1;
          busy_ff     <= 1'b0;
        end else begin
          busy_ff  <= 1'b1;
          count_ff <= `CPA_CNT_ONE;
        end
      end else if (busy_ff) begin
        if (count_ff == levelWindowOffset) begin
          windowStart <= 1'b1;
          busy_ff     <= 1'b0;
        end else begin
          count_ff <= count_ff + `CPA_CNT_ONE;
        end
      end
    end
  end
endmodule

// file: cpa_short_pulse.v
// sync-processing reset request when consecutive short pulses exceed a threshold
// assumes shortPulse and longPulse are one-cycle strobes from the sync measurement logic
`timescale 1ns/1ns
`include "cpa_consts.vh"
module cpa_short_pulse (
  input  wire       clock,
  input  wire       rst_n,
  input  wire       shortPulse,
  input  wire       longPulse,
  input  wire [7:0] threshold,
  output reg        syncReset
);
  reg [8:0] count_ff;

  always @(posedge clock) begin
    if (!rst_n) begin
      count_ff  <= 9'h000;
      syncReset <= 1'b0;
    end else begin
      syncReset <= 1'b0;
      if (longPulse) begin
        count_ff <= 9'h000;
      end else if (shortPulse) begin
        if ((count_ff + 9'h001) > {1'b0, threshold}) begin
          syncReset <= 1'b1;
          count_ff  <= 9'h000;
        end else begin
          count_ff <= count_ff + 9'h001;
        end
      end
    end
  end
endmodule

// file: cpa_clamp_power_regs.v
// clamp, power-down, converter bias, droop, level-window and sync threshold registers
// assumes the serial control front end presents a decoded subaddress with a one-cycle write strobe
//
// Contract
// - fine clamp: offset enable bit7, time constant bits4:3, GB/R enables bits1:0.
// - common-mode offset acts only with fine bottom-level clamp selected.
// - any coarse clamp enable forces all fine clamps off.
// - power register: active-high power-downs at bits 6..0, default zero.
// - converter bias code bits7:4 default 5h, green-sync clamp bias bits3:0 default 0.
// - green-sync clamp bias current equals 2 plus 2 times code microamps.
// - coarse clamp: charge select 7:6, bits 5:3 fixed zero, enables 2:0, reset 00h.
// - green-sync clamp: enable bit7, charge select 6:5, low bits zero, reset 80h.
// - rgb droop code bits5:0, register resets to 8Ch.
// - green-sync droop code bits5:0, resets 04h, current follows clamp bias.
// - level window starts programmed clocks after chosen sync edge, trailing default.
// - sync processing resets when consecutive short pulses exceed the threshold.
`timescale 1ns/1ns
`include "cpa_consts.vh"
module cpa_clamp_power_regs (
  input  wire       clock,
  input  wire       rst_n,
  input  wire [7:0] regAddr,
  input  wire [7:0] regWrData,
  input  wire       regWrEn,
  output reg  [7:0] regRdData,
  output wire       regHit,
  input  wire       midLevelClamp,
  input  wire       edgeLeading,
  input  wire       hsync,
  input  wire       shortPulse,
  input  wire       longPulse,
  output wire       common_mode_offset_en,
  output wire [1:0] fineTimeConstant,
  output wire       fine_clamp_green_blue_en,
  output wire       fineClampRedEn,
  output wire [1:0] rgb_clamp_charge_select,
  output wire [2:0] coarseClampEn,
  output wire       greenSyncPowerdown,
  output wire       slicerPowerdown,
  output wire       referencePowerdown,
  output wire       currentCtrlPowerdown,
  output wire       blue_converter_powerdown,
  output wire       green_converter_powerdown,
  output wire       red_converter_powerdown,
  output wire [3:0] converterBias,
  output wire [5:0] clamp_bias_current,
  output wire       greenSyncClampEn,
  output wire [1:0] greenSyncChargeSelect,
  output wire [5:0] rgb_droop_code,
  output wire [5:0] greenSyncDroopCode,
  output wire [7:0] copyProtectThreshold,
  output wire       levelWindowStart,
  output wire       syncProcReset
);
  reg  [7:0] fine_ff;
  reg  [7:0] power_ff;
  reg  [7:0] conv_ff;
  reg  [7:0] coarse_ff;
  reg  [7:0] gsync_ff;
  reg  [7:0] rgbDroop_ff;
  reg  [7:0] gsDroop_ff;
  reg  [7:0] levelPos_ff;
  reg  [7:0] cpThr_ff;
  reg  [7:0] spThr_ff;
  reg  [7:0] nxt_fine;
  reg  [7:0] nxt_power;
  reg  [7:0] nxt_conv;
  reg  [7:0] nxt_coarse;
  reg  [7:0] nxt_gsync;
  reg  [7:0] nxt_rgbDroop;
  reg  [7:0] nxt_gsDroop;
  reg  [7:0] nxt_levelPos;
  reg  [7:0] nxt_cpThr;
  reg  [7:0] nxt_spThr;
  wire [9:0] wrSel;
  wire       anyCoarse;

  // merge a write under a mask; masked-off bits keep fixed values
  function [7:0] cpa_merge;
    input [7:0] data;
    input [7:0] mask;
    input [7:0] fixed;
    begin
      cpa_merge = (data & mask) | (fixed & ~mask);
    end
  endfunction

  function cpa_hit;
    input [7:0] addr;
    begin
      cpa_hit = (addr >= `CPA_ADDR_FINE) && (addr <= `CPA_ADDR_SPTHR);
    end
  endfunction

  assign regHit = cpa_hit(regAddr);

  // one write strobe per register, decoded from the subaddress
  // unmapped subaddresses raise no strobe, so such writes are dropped
  genvar gi;
  generate
    for (gi = 0; gi <= `CPA_ADDR_SPTHR - `CPA_ADDR_FINE; gi = gi + 1) begin : gWrSel
      assign wrSel[gi] = regWrEn & (regAddr == `CPA_ADDR_FINE + gi);
    end
  endgenerate

  // each register: next value from the write data under its mask, then a plain flop;
  // masked-off bits are forced so readback never shows a reserved bit as written

  // fine clamp control
  always @* begin
    if (wrSel[0]) begin
      nxt_fine = cpa_merge(regWrData, `CPA_WMASK_FINE, `CPA_FIX_FINE);
    end else begin
      nxt_fine = fine_ff;
    end
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      fine_ff <= `CPA_RST_FINE;
    end else begin
      fine_ff <= nxt_fine;
    end
  end

  // power-down control
  always @* begin
    if (wrSel[1]) begin
      nxt_power = cpa_merge(regWrData, `CPA_WMASK_POWER, `CPA_RST_POWER);
    end else begin
      nxt_power = power_ff;
    end
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      power_ff <= `CPA_RST_POWER;
    end else begin
      power_ff <= nxt_power;
    end
  end

  // converter and clamp bias setup
  always @* begin
    if (wrSel[2]) begin
      nxt_conv = cpa_merge(regWrData, `CPA_WMASK_FULL, `CPA_RST_CONV);
    end else begin
      nxt_conv = conv_ff;
    end
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      conv_ff <= `CPA_RST_CONV;
    end else begin
      conv_ff <= nxt_conv;
    end
  end

  // coarse clamp control
  always @* begin
    if (wrSel[3]) begin
      nxt_coarse = cpa_merge(regWrData, `CPA_WMASK_COARSE, `CPA_RST_COARSE);
    end else begin
      nxt_coarse = coarse_ff;
    end
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      coarse_ff <= `CPA_RST_COARSE;
    end else begin
      coarse_ff <= nxt_coarse;
    end
  end

  // green-sync clamp
  always @* begin
    if (wrSel[4]) begin
      nxt_gsync = cpa_merge(regWrData, `CPA_WMASK_GSYNC, `CPA_RST_GSYNC);
    end else begin
      nxt_gsync = gsync_ff;
    end
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      gsync_ff <= `CPA_RST_GSYNC;
    end else begin
      gsync_ff <= nxt_gsync;
    end
  end

  // rgb droop code
  always @* begin
    if (wrSel[5]) begin
      nxt_rgbDroop = cpa_merge(regWrData, `CPA_WMASK_DROOP, `CPA_RST_RGBDROOP);
    end else begin
      nxt_rgbDroop = rgbDroop_ff;
    end
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      rgbDroop_ff <= `CPA_RST_RGBDROOP;
    end else begin
      rgbDroop_ff <= nxt_rgbDroop;
    end
  end

  // green-sync droop code
  always @* begin
    if (wrSel[6]) begin
      nxt_gsDroop = cpa_merge(regWrData, `CPA_WMASK_DROOP, `CPA_RST_GSDROOP);
    end else begin
      nxt_gsDroop = gsDroop_ff;
    end
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      gsDroop_ff <= `CPA_RST_GSDROOP;
    end else begin
      gsDroop_ff <= nxt_gsDroop;
    end
  end

  // level window position
  always @* begin
    if (wrSel[7]) begin
      nxt_levelPos = cpa_merge(regWrData, `CPA_WMASK_FULL, `CPA_RST_LEVELPOS);
    end else begin
      nxt_levelPos = levelPos_ff;
    end
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      levelPos_ff <= `CPA_RST_LEVELPOS;
    end else begin
      levelPos_ff <= nxt_levelPos;
    end
  end

  // copy-protection threshold, only stored and passed on
  always @* begin
    if (wrSel[8]) begin
      nxt_cpThr = cpa_merge(regWrData, `CPA_WMASK_FULL, `CPA_RST_CPTHR);
    end else begin
      nxt_cpThr = cpThr_ff;
    end
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      cpThr_ff <= `CPA_RST_CPTHR;
    end else begin
      cpThr_ff <= nxt_cpThr;
    end
  end

  // short pulse threshold
  always @* begin
    if (wrSel[9]) begin
      nxt_spThr = cpa_merge(regWrData, `CPA_WMASK_FULL, `CPA_RST_SPTHR);
    end else begin
      nxt_spThr = spThr_ff;
    end
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      spThr_ff <= `CPA_RST_SPTHR;
    end else begin
      spThr_ff <= nxt_spThr;
    end
  end

  // readback; unmapped subaddresses read zero
  always @* begin
    case (regAddr)
      `CPA_ADDR_FINE:     regRdData = fine_ff;
      `CPA_ADDR_POWER:    regRdData = power_ff;
      `CPA_ADDR_CONV:     regRdData = conv_ff;
      `CPA_ADDR_COARSE:   regRdData = coarse_ff;
      `CPA_ADDR_GSYNC:    regRdData = gsync_ff;
      `CPA_ADDR_RGBDROOP: regRdData = rgbDroop_ff;
      `CPA_ADDR_GSDROOP:  regRdData = gsDroop_ff;
      `CPA_ADDR_LEVELPOS: regRdData = levelPos_ff;
      `CPA_ADDR_CPTHR:    regRdData = cpThr_ff;
      `CPA_ADDR_SPTHR:    regRdData = spThr_ff;
      default:            regRdData = 8'h00;
    endcase
  end

  assign anyCoarse = |coarse_ff[2:0];

  // offset only with fine bottom-level clamp and no coarse clamp
  assign common_mode_offset_en    = fine_ff[`CPA_BIT_CMOFS] & ~anyCoarse & ~midLevelClamp;
  assign fineTimeConstant         = fine_ff[4:3];
  assign fine_clamp_green_blue_en = fine_ff[`CPA_BIT_FINE_CLAMP_GREEN_BLUE_EN] & ~anyCoarse;
  assign fineClampRedEn           = fine_ff[`CPA_BIT_FINE_R] & ~anyCoarse;

  assign rgb_clamp_charge_select = coarse_ff[7:6];
  assign coarseClampEn           = coarse_ff[2:0];

  assign greenSyncPowerdown        = power_ff[6];
  assign slicerPowerdown           = power_ff[5];
  assign referencePowerdown        = power_ff[4];
  assign currentCtrlPowerdown      = power_ff[3];
  assign blue_converter_powerdown  = power_ff[2];
  assign green_converter_powerdown = power_ff[1];
  assign red_converter_powerdown   = power_ff[0];

  assign converterBias = conv_ff[7:4];
  // current in microamps: 2 + 2*N, range 2..32
  assign clamp_bias_current = `CPA_BIAS_BASE + {1'b0, conv_ff[3:0], 1'b0};

  assign greenSyncClampEn      = gsync_ff[`CPA_BIT_GSYNC_EN];
  assign greenSyncChargeSelect = gsync_ff[6:5];
  assign rgb_droop_code        = rgbDroop_ff[5:0];
  assign greenSyncDroopCode    = gsDroop_ff[5:0];
  assign copyProtectThreshold  = cpThr_ff;

  cpa_level_window uWindow (
    .clock             (clock),
    .rst_n             (rst_n),
    .hsync             (hsync),
    .edgeLeading       (edgeLeading),
    .levelWindowOffset (levelPos_ff),
    .windowStart       (levelWindowStart)
  );

  cpa_short_pulse uShort (
    .clock      (clock),
    .rst_n      (rst_n),
    .shortPulse (shortPulse),
    .longPulse  (longPulse),
    .threshold  (spThr_ff),
    .syncReset  (syncProcReset)
  );
endmodule

// file: cpa_regs_monitor.sv
// checker for the clamp, power and level-control register group
// assumes it is bound onto cpa_clamp_power_regs, one clock domain
`timescale 1ns/1ns
module cpa_regs_monitor (
  input wire       clock,
  input wire       rst_n,
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire       regWrEn,
  input wire [7:0] regRdData,
  input wire       midLevelClamp,
  input wire       shortPulse,
  input wire       common_mode_offset_en,
  input wire [1:0] fineTimeConstant,
  input wire       fine_clamp_green_blue_en,
  input wire       fineClampRedEn,
  input wire [2:0] coarseClampEn,
  input wire [5:0] clamp_bias_current,
  input wire       greenSyncClampEn,
  input wire [5:0] rgb_droop_code,
  input wire       syncProcReset
);
  reg [5:0] lastWr_ff;
  always @(posedge clock) begin
    lastWr_ff <= regWrData[5:0];
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_coarse_kills_fine: assert property (|coarseClampEn |-> !fine_clamp_green_blue_en && !fineClampRedEn)
    else $error("fine clamp left on beside coarse clamp");
  a_offset_gated: assert property (common_mode_offset_en |-> !midLevelClamp && coarseClampEn == 3'h0)
    else $error("offset enable active outside bottom fine clamp");
  a_fine_fields: assert property (regAddr == 8'h2a |-> fineTimeConstant == regRdData[4:3] && regRdData[2])
    else $error("fine clamp fields wrong");
  a_bias_current: assert property (regAddr == 8'h2c |-> clamp_bias_current == {1'b0, regRdData[3:0], 1'b0} + 6'h02)
    else $error("clamp bias current wrong");
  a_coarse_rsvd: assert property (regAddr == 8'h2d |-> regRdData[5:3] == 3'h0 && coarseClampEn == regRdData[2:0])
    else $error("coarse clamp fields wrong");
  a_gsync_fields: assert property (regAddr == 8'h2e |-> regRdData[4:0] == 5'h0 && greenSyncClampEn == regRdData[7])
    else $error("green sync clamp fields wrong");
  a_droop_write: assert property (regWrEn && regAddr == 8'h2f |=> rgb_droop_code == lastWr_ff)
    else $error("droop code not updated by write");
  a_reset_cause: assert property (syncProcReset |-> $past(shortPulse))
    else $error("sync reset without short pulse");
  c_coarse: cover property (regWrEn && regAddr == 8'h2d ##1 |coarseClampEn);
  c_offset: cover property (common_mode_offset_en);
  c_reset: cover property (syncProcReset);
endmodule

// file: test_clamp_power_alc_config_regs.sv
// self-checking bench for the clamp, power and level-control registers
// assumes the design files and cpa_regs_monitor.sv are compiled first
`timescale 1ns/1ns
module test_clamp_power_alc_config_regs;
  reg        clock, rst_n, regWrEn, midLevelClamp, edgeLeading, hsync, shortPulse, longPulse, seen;
  reg  [7:0] regAddr, regWrData, e, thr;
  wire [7:0] regRdData, copyProtectThreshold;
  wire [5:0] clamp_bias_current, rgb_droop_code, greenSyncDroopCode;
  wire [3:0] converterBias;
  wire [2:0] coarseClampEn;
  wire [1:0] fineTimeConstant, rgb_clamp_charge_select, greenSyncChargeSelect;
  wire       regHit, common_mode_offset_en, fine_clamp_green_blue_en, fineClampRedEn, greenSyncPowerdown;
  wire       slicerPowerdown, referencePowerdown, currentCtrlPowerdown, blue_converter_powerdown;
  wire       green_converter_powerdown, red_converter_powerdown, greenSyncClampEn, levelWindowStart, syncProcReset;
  integer    num_errors, compares, i, k, n, t;
  cpa_clamp_power_regs dut (.clock, .rst_n, .regAddr, .regWrData, .regWrEn, .regRdData, .regHit, .midLevelClamp,
    .edgeLeading, .hsync, .shortPulse, .longPulse, .common_mode_offset_en, .fineTimeConstant, .fine_clamp_green_blue_en,
    .fineClampRedEn, .rgb_clamp_charge_select, .coarseClampEn, .greenSyncPowerdown, .slicerPowerdown,
    .referencePowerdown, .currentCtrlPowerdown, .blue_converter_powerdown, .green_converter_powerdown,
    .red_converter_powerdown, .converterBias, .clamp_bias_current, .greenSyncClampEn, .greenSyncChargeSelect,
    .rgb_droop_code, .greenSyncDroopCode, .copyProtectThreshold, .levelWindowStart, .syncProcReset);
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  function [7:0] rstv(input [7:0] a);
    case (a)
      8'h2a: rstv = 8'h07;
      8'h2c: rstv = 8'h50;
      8'h2e: rstv = 8'h80;
      8'h2f: rstv = 8'h8c;
      8'h30: rstv = 8'h04;
      8'h31: rstv = 8'h5a;
      8'h32: rstv = 8'h18;
      8'h33: rstv = 8'h60;
      default: rstv = 8'h00;
    endcase
  endfunction
  function [7:0] expv(input [7:0] a, input [7:0] d);
    case (a)
      8'h2a: expv = d & 8'h9b | 8'h04;
      8'h2b: expv = d & 8'h7f;
      8'h2d: expv = d & 8'hc7;
      8'h2e: expv = d & 8'he0;
      8'h2f: expv = d & 8'h3f | 8'h80;
      8'h30: expv = d & 8'h3f;
      default: expv = d;
    endcase
  endfunction
  // output fields of a register packed back into register layout; 2a, 31, 33 and the 2c bias nibble reuse readback
  function [7:0] outv(input [7:0] a);
    case (a)
      8'h2b: outv = {1'b0, greenSyncPowerdown, slicerPowerdown, referencePowerdown, currentCtrlPowerdown,
                     blue_converter_powerdown, green_converter_powerdown, red_converter_powerdown};
      8'h2c: outv = {converterBias, regRdData[3:0]};
      8'h2d: outv = {rgb_clamp_charge_select, 3'h0, coarseClampEn};
      8'h2e: outv = {greenSyncClampEn, greenSyncChargeSelect, 5'h00};
      8'h2f: outv = {2'h2, rgb_droop_code};
      8'h30: outv = {2'h0, greenSyncDroopCode};
      8'h32: outv = copyProtectThreshold;
      default: outv = regRdData;
    endcase
  endfunction
  task chk(input string nm, input [7:0] ex, input [7:0] sn);
    begin
      compares = compares + 1;
      if (sn !== ex) begin
        num_errors = num_errors + 1;
        $display("MISMATCH %s expected %h seen %h", nm, ex, sn);
      end
    end
  endtask
  task cyc;
    begin
      @(posedge clock);
      #2;
    end
  endtask
  // strobe stays up so writes can follow back to back
  task wr(input [7:0] a, input [7:0] d);
    begin
      regAddr = a;
      regWrData = d;
      regWrEn = 1'b1;
      cyc;
    end
  endtask
  task rd(input [7:0] a, input [7:0] ex);
    begin
      regWrEn = 1'b0;
      regAddr = a;
      #1;
      chk("regRdData", ex, regRdData);
      chk("fields", ex, outv(a));
      chk("regHit", {7'h0, a >= 8'h2a && a <= 8'h33}, {7'h0, regHit});
      cyc;
    end
  endtask
  task win(input [7:0] nn, input lead);
    begin
      wr(8'h31, nn);
      regWrEn = 1'b0;
      edgeLeading = lead;
      hsync = ~lead;
      repeat (3) cyc;
      hsync = lead;
      k = 0;
      t = 0;
      while (t == 0 && k < 300) begin
        cyc;
        k = k + 1;
        if (levelWindowStart === 1'b1) t = 1;
      end
      chk("windowDelay", nn + 8'h01, k[7:0]);
    end
  endtask
  task spr(input [7:0] th, input [7:0] cnt, input brk, input ex);
    begin
      wr(8'h33, th);
      regWrEn = 1'b0;
      longPulse = 1'b1;
      cyc;
      seen = 1'b0;
      for (k = 0; k < cnt + 3; k = k + 1) begin
        shortPulse = k < cnt;
        longPulse = brk && k == cnt / 2;
        cyc;
        if (syncProcReset === 1'b1) seen = 1'b1;
      end
      chk("syncReset", {7'h0, ex}, {7'h0, seen});
    end
  endtask
  task results;
    begin
      $display("num_errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial begin
    #1000000;
    num_errors = num_errors + 1;
    results;
  end
  initial begin
    {rst_n, regWrEn, midLevelClamp, edgeLeading, shortPulse, longPulse} = 6'h00;
    {hsync, regAddr, regWrData} = 17'h10000;
    num_errors = 0;
    compares = 0;
    void'($urandom(32'hbfed));
    repeat (10) @(posedge clock);
    #2;
    rst_n = 1'b1;
    for (i = 8'h2a; i <= 8'h33; i = i + 1) rd(i[7:0], rstv(i[7:0]));
    for (n = 0; n < 3; n = n + 1) begin
      for (i = 8'h2a; i <= 8'h33; i = i + 1) begin
        e = $urandom;
        if (i == 8'h2a) e = e | 8'h03;
        if (i == 8'h32) e = 8'h18;
        wr(i[7:0], e);
        rd(i[7:0], expv(i[7:0], e));
      end
    end
    wr(8'h2d, 8'h00);
    wr(8'h34, 8'hff);
    wr(8'h2a, 8'h9b);
    rd(8'h34, 8'h00);
    chk("regHit", 8'h00, {7'h0, regHit});
    rd(8'h2a, 8'h9f);
    chk("timeConst", 8'h03, {6'h0, fineTimeConstant});
    chk("offsetEn", 8'h07, {5'h0, common_mode_offset_en, fine_clamp_green_blue_en, fineClampRedEn});
    midLevelClamp = 1'b1;
    cyc;
    chk("offsetEn", 8'h00, {7'h0, common_mode_offset_en});
    midLevelClamp = 1'b0;
    for (k = 1; k < 8; k = k + 1) begin
      wr(8'h2d, k[7:0]);
      rd(8'h2d, k[7:0]);
      chk("fineEn", 8'h00, {5'h0, common_mode_offset_en, fine_clamp_green_blue_en, fineClampRedEn});
    end
    for (n = 0; n < 16; n = n + 1) begin
      wr(8'h2c, 8'h50 | n[7:0]);
      rd(8'h2c, 8'h50 | n[7:0]);
      chk("biasCurrent", 8'h02 + 8'h02 * n[7:0], {2'h0, clamp_bias_current});
    end
    win(8'h00, 1'b0);
    win(8'h03, 1'b1);
    win($urandom % 40, 1'b0);
    thr = $urandom % 6;
    spr(thr, thr, 1'b0, 1'b0);
    spr(thr, thr + 8'h01, 1'b0, 1'b1);
    spr(thr, thr + 8'h01, 1'b1, 1'b0);
    spr(8'h00, 8'h01, 1'b0, 1'b1);
    spr(8'h60, 8'h61, 1'b0, 1'b1);
    rst_n = 1'b0;
    repeat (2) cyc;
    rst_n = 1'b1;
    for (i = 8'h2a; i <= 8'h33; i = i + 1) rd(i[7:0], rstv(i[7:0]));
    results;
  end
endmodule
bind cpa_clamp_power_regs cpa_regs_monitor mon (.clock, .rst_n, .regAddr, .regWrData, .regWrEn, .regRdData,
  .midLevelClamp, .shortPulse, .common_mode_offset_en, .fineTimeConstant, .fine_clamp_green_blue_en, .fineClampRedEn,
  .coarseClampEn, .clamp_bias_current, .greenSyncClampEn, .rgb_droop_code, .syncProcReset);
